// ---- bemf_stall_defs.svh ----
// Constants and macros for the back-EMF stall detector
`ifndef BEMF_STALL_DEFS_SVH
`define BEMF_STALL_DEFS_SVH

`define CLK_PERIOD_NS 10
`define DLY_US_0 87
`define DLY_US_1 130
`define DLY_US_2 174
`define DLY_US_3 217
`define DLY_US_4 261
`define DLY_US_5 304
`define DLY_US_6 348
`define DLY_US_7 391
`define US_TO_CYC(us) ((us) * 1000 / `CLK_PERIOD_NS)
`define THR_DISABLED 4'h0
`define ABS_STEP_MV 500
`define DEL_STEP_MV 250
`define OFF_BYTE 8'h00

`endif

// ---- bemf_stall_pkg.sv ----
// Shared types for the back-EMF stall detector
package bemf_stall_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_DELAY,
    ST_SAMPLE
  } sample_state_t;
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_FIRST,
    PH_STAB,
    PH_SECOND
  } move_phase_t;
endpackage

// ---- bemf_sample_timer.sv ----
// Post-zero-crossing sample delay timer
`timescale 1ns/1ps
`include "bemf_stall_defs.svh"
module bemf_sample_timer
  import bemf_stall_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk_in, // Clock
  input wire logic rst_in, // Async reset
  input wire logic zero_cross_in, // Back-EMF zero crossing pulse
  input wire logic [2:0] sample_delay_sel_in, // Delay selector
  output logic sample_take_out // One-cycle sample strobe
);
  localparam logic [CNT_W-1:0] CYC [8] = '{
    CNT_W'(`US_TO_CYC(`DLY_US_0)), CNT_W'(`US_TO_CYC(`DLY_US_1)),
    CNT_W'(`US_TO_CYC(`DLY_US_2)), CNT_W'(`US_TO_CYC(`DLY_US_3)),
    CNT_W'(`US_TO_CYC(`DLY_US_4)), CNT_W'(`US_TO_CYC(`DLY_US_5)),
    CNT_W'(`US_TO_CYC(`DLY_US_6)), CNT_W'(`US_TO_CYC(`DLY_US_7))};
  if (`US_TO_CYC(`DLY_US_7) >= (1 << CNT_W)) begin : g_bad_cnt
    $error("CNT_W too small for delay");
  end

  sample_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  wire logic [CNT_W-1:0] target = CYC[sample_delay_sel_in];
  wire logic expired = (state_r == ST_WAIT_DELAY) && (cnt_r >= target - CNT_W'(1));

  // RQ14
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cnt_r <= '0;
          if (zero_cross_in) state_r <= ST_WAIT_DELAY;
        end
        ST_WAIT_DELAY: begin
          // A new crossing restarts the wait
          if (zero_cross_in) cnt_r <= '0;
          else if (expired) state_r <= ST_SAMPLE;
          else cnt_r <= cnt_r + CNT_W'(1);
        end
        ST_SAMPLE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  assign sample_take_out = (state_r == ST_SAMPLE);
endmodule

// ---- bemf_stall_detector.sv ----
// Back-EMF stall detection, flags and position stop logic
// Operation
// RQ1 - Set absolute stall flag when averaged back-EMF falls below absolute threshold.
// RQ2 - Set delta-high flag when sample exceeds average plus delta threshold.
// RQ3 - Set delta-low flag when sample drops below average minus delta threshold.
// RQ4 - Combined stall flag is OR of delta-low, delta-high and absolute flags.
// RQ5 - Evaluate stall only at maximum velocity, never during ramps.
// RQ6 - Stall during a move causes immediate halt and sets stall and lost-step.
// RQ7 - Two-phase move: stall cancels phase one, phase two at minimum velocity after stabilisation.
// RQ8 - Stall halt copies internal step counter into actual position.
// RQ9 - Full status read returns then clears all five flags; positioning resumes.
// RQ10 - Short status read clears only the lost-step flag.
// RQ11 - Detection disabled when both RAM thresholds are zero.
// RQ12 - Master writes RAM or OTP thresholds; OTP copied to RAM at power-on reset.
// RQ13 - Index zero disables; levels are 0.5 V and 0.25 V per index step.
// RQ14 - Sample taken after selected delay following each zero crossing; a crossing during the wait restarts it, one in the sample cycle is dropped.
// RQ15 - Detection active after ramp plus selected extra full steps, 0 to 7.
// RQ16 - Configuration bit keeps detection enabled at 100 percent duty.
// RQ17 - Observation command enters qualification mode until power-on reset.
// RQ18 - Switch input reading blocked while qualification mode is active.
// RQ19 - All stall flags reported in both short and full status replies.
// RQ20 - Moving-average window length is a design parameter.
`timescale 1ns/1ps
`include "bemf_stall_defs.svh"
module bemf_stall_detector
  import bemf_stall_pkg::*;
#(
  parameter int AVG_LOG2 = 3, // Window is 2**AVG_LOG2 samples
  parameter int BEMF_W = 14, // Sample width, millivolts
  parameter int POS_W = 16,
  parameter int STAB_CYC = 1000 // Stabilisation timeout in cycles
) (
  input wire logic ref_clk_in, // Clock
  input wire logic rst_in, // Async reset, power-on
  input wire logic zero_cross_in, // Back-EMF zero crossing
  input wire logic [BEMF_W-1:0] bemf_mv_in, // Back-EMF sample in mV
  input wire logic [2:0] sample_delay_sel_in, // Sample delay selector
  input wire logic [2:0] stall_activation_step_delay_in, // Extra full steps
  input wire logic full_duty_stall_enable_in, // Keep detecting at 100% duty
  input wire logic duty_full_in, // Coil PWM at 100% duty
  input wire logic at_max_velocity_in, // Motor at maximum velocity
  input wire logic full_step_in, // One full step done pulse
  input wire logic moving_in, // Positioning move active
  input wire logic two_phase_positioning_in, // Move is two-phase
  input wire logic [POS_W-1:0] step_counter_in, // Internal step counter
  input wire logic [3:0] otp_absolute_threshold_in, // OTP absolute index
  input wire logic [3:0] otp_delta_threshold_in, // OTP delta index
  input wire logic stall_param_write_cmd_in, // Write RAM thresholds
  input wire logic otp_param_write_cmd_in, // Write OTP thresholds
  input wire logic [3:0] absolute_threshold_in, // Written absolute index
  input wire logic [3:0] delta_threshold_in, // Written delta index
  input wire logic full_status_read_cmd_in, // Full status read
  input wire logic short_status_read_cmd_in, // Short status read
  input wire logic bemf_observe_cmd_in, // Enter qualification mode
  input wire logic switch_input_pin_in, // Switch input level
  output logic [4:0] status_flags_out, // {lost,stall,abs,lo,hi}
  output logic halt_out, // Immediate halt pulse
  output logic start_second_phase_out, // Start phase two at Vmin
  output logic [POS_W-1:0] actual_position_out, // Actual position
  output logic [3:0] absolute_threshold_out, // RAM absolute index
  output logic [3:0] delta_threshold_out, // RAM delta index
  output logic otp_write_out, // OTP programming strobe
  output logic [3:0] otp_abs_data_out, // OTP absolute data
  output logic [3:0] otp_del_data_out, // OTP delta data
  output logic qualification_mode_out, // Switch pin as analog out
  output logic switch_state_out // Switch state, blocked in mode
);
  // Accumulator and window sizing only hold for these ranges
  if (AVG_LOG2 < 1 || AVG_LOG2 > 6) begin : g_bad_avg
    $error("AVG_LOG2 out of range");
  end
  if (STAB_CYC < 1) begin : g_bad_stab
    $error("STAB_CYC must be positive");
  end
  // Narrower samples would truncate the highest threshold levels
  if (BEMF_W < 13) begin : g_bad_bemf
    $error("BEMF_W too narrow for threshold levels");
  end
  localparam int ACC_W = BEMF_W + AVG_LOG2;

  // Threshold RAM; OTP image loaded after reset release
  logic [3:0] abs_thr_r;
  logic [3:0] del_thr_r;
  logic loaded_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      abs_thr_r <= `THR_DISABLED;
      del_thr_r <= `THR_DISABLED;
      loaded_r <= 1'b0;
    end else if (!loaded_r) begin
      abs_thr_r <= otp_absolute_threshold_in; // RQ12
      del_thr_r <= otp_delta_threshold_in; // RQ12
      loaded_r <= 1'b1;
    end else if (stall_param_write_cmd_in) begin
      abs_thr_r <= absolute_threshold_in; // RQ12
      del_thr_r <= delta_threshold_in;
    end
  end
  assign absolute_threshold_out = abs_thr_r;
  assign delta_threshold_out = del_thr_r;

  // OTP programming strobe, registered
  logic otp_wr_r;
  logic [3:0] otp_abs_r;
  logic [3:0] otp_del_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      otp_wr_r <= 1'b0;
      otp_abs_r <= `THR_DISABLED;
      otp_del_r <= `THR_DISABLED;
    end else begin
      otp_wr_r <= otp_param_write_cmd_in; // RQ12
      if (otp_param_write_cmd_in) begin
        otp_abs_r <= absolute_threshold_in;
        otp_del_r <= delta_threshold_in;
      end
    end
  end
  assign otp_write_out = otp_wr_r;
  assign otp_abs_data_out = otp_abs_r;
  assign otp_del_data_out = otp_del_r;

  // Threshold levels in mV
  wire logic [BEMF_W-1:0] abs_lvl = BEMF_W'(abs_thr_r * `ABS_STEP_MV); // RQ13
  wire logic [BEMF_W-1:0] del_lvl = BEMF_W'(del_thr_r * `DEL_STEP_MV); // RQ13
  wire logic abs_on = (abs_thr_r != `THR_DISABLED); // RQ13
  wire logic del_on = (del_thr_r != `THR_DISABLED);
  wire logic detect_en = abs_on || del_on; // RQ11

  // Sample strobe
  logic sample_take;
  bemf_sample_timer u_timer (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .zero_cross_in(zero_cross_in),
    .sample_delay_sel_in(sample_delay_sel_in),
    .sample_take_out(sample_take)
  );

  // Activation delay in full steps after reaching max velocity
  logic [2:0] steps_r;
  logic armed_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      steps_r <= 3'h0;
      armed_r <= 1'b0;
    end else if (!at_max_velocity_in || !moving_in) begin
      steps_r <= 3'h0; // RQ5
      armed_r <= 1'b0;
    end else if (!armed_r) begin
      if (steps_r >= stall_activation_step_delay_in) armed_r <= 1'b1; // RQ15
      else if (full_step_in) steps_r <= steps_r + 3'h1;
    end
  end

  // Moving average over a sliding window; a stale window at start is avoided
  // by restarting the fill each time the motor leaves maximum velocity
  localparam int N = 1 << AVG_LOG2;
  logic [BEMF_W-1:0] win_r [N];
  logic [ACC_W-1:0] sum_r;
  logic [AVG_LOG2:0] fill_r;
  wire logic win_full = fill_r[AVG_LOG2];
  wire logic [BEMF_W-1:0] avg = BEMF_W'(sum_r >> AVG_LOG2); // RQ20
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sum_r <= '0;
      fill_r <= '0;
    end else if (!at_max_velocity_in) begin
      sum_r <= '0;
      fill_r <= '0;
    end else if (sample_take) begin
      sum_r <= sum_r + ACC_W'(bemf_mv_in) - ACC_W'(win_full ? win_r[N-1] : '0); // RQ20
      if (!win_full) fill_r <= fill_r + 1'b1;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_win
      always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) win_r[gi] <= '0;
        else if (sample_take) win_r[gi] <= (gi == 0) ? bemf_mv_in : win_r[(gi == 0) ? 0 : gi - 1];
      end
    end
  endgenerate

  // Evaluation qualifiers
  wire logic duty_ok = !duty_full_in || full_duty_stall_enable_in; // RQ16
  wire logic eval = sample_take && armed_r && at_max_velocity_in && detect_en && duty_ok && win_full; // RQ5
  wire logic [BEMF_W:0] hi_lim = {1'b0, avg} + {1'b0, del_lvl};
  wire logic hit_abs = eval && abs_on && (avg < abs_lvl); // RQ1
  wire logic hit_hi = eval && del_on && ({1'b0, bemf_mv_in} > hi_lim); // RQ2
  wire logic hit_lo = eval && del_on && (avg > del_lvl) && (bemf_mv_in < avg - del_lvl); // RQ3
  wire logic hit_any = hit_abs || hit_hi || hit_lo;

  // Sticky flags; a new event wins over a clear in the same cycle
  logic abs_r, hi_r, lo_r, stall_r, lost_r;
  wire logic clr_full = full_status_read_cmd_in; // RQ9
  wire logic clr_lost = full_status_read_cmd_in || short_status_read_cmd_in; // RQ10
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      abs_r <= 1'b0;
      hi_r <= 1'b0;
      lo_r <= 1'b0;
      stall_r <= 1'b0;
      lost_r <= 1'b0;
    end else begin
      abs_r <= hit_abs || (abs_r && !clr_full); // RQ1
      hi_r <= hit_hi || (hi_r && !clr_full); // RQ2
      lo_r <= hit_lo || (lo_r && !clr_full); // RQ3
      stall_r <= hit_any || (stall_r && !clr_full); // RQ4
      lost_r <= (hit_any && moving_in) || (lost_r && !clr_lost); // RQ6
    end
  end
  // Flags as they stand before the read takes effect
  assign status_flags_out = {lost_r, stall_r, abs_r, lo_r, hi_r}; // RQ19

  // Halt, position capture and two-phase sequencing
  wire logic stall_stop = hit_any && moving_in;
  move_phase_t phase_r;
  logic [$clog2(STAB_CYC+1)-1:0] stab_r;
  logic halt_r, second_r;
  logic [POS_W-1:0] pos_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_r <= PH_IDLE;
      stab_r <= '0;
      halt_r <= 1'b0;
      second_r <= 1'b0;
      pos_r <= '0;
    end else begin
      halt_r <= stall_stop; // RQ6
      second_r <= 1'b0;
      // Position only follows the counter while no stall is pending
      if (stall_stop) pos_r <= step_counter_in; // RQ8
      else if (!stall_r && moving_in) pos_r <= step_counter_in; // RQ9
      case (phase_r)
        PH_IDLE: if (moving_in && two_phase_positioning_in) phase_r <= PH_FIRST;
        PH_FIRST: begin
          if (stall_stop) begin
            phase_r <= PH_STAB; // RQ7
            stab_r <= '0;
          end else if (!moving_in) phase_r <= PH_IDLE;
        end
        PH_STAB: begin
          if (stab_r == $bits(stab_r)'(STAB_CYC - 1)) begin
            phase_r <= PH_SECOND;
            second_r <= 1'b1; // RQ7
          end else stab_r <= stab_r + 1'b1;
        end
        PH_SECOND: phase_r <= PH_IDLE;
        default: phase_r <= PH_IDLE;
      endcase
    end
  end
  assign halt_out = halt_r;
  assign start_second_phase_out = second_r;
  assign actual_position_out = pos_r;

  // Qualification mode, left only by reset
  logic qual_r;
  logic sw_r;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      qual_r <= 1'b0;
      sw_r <= 1'b0;
    end else begin
      if (bemf_observe_cmd_in) qual_r <= 1'b1; // RQ17
      if (!qual_r && !bemf_observe_cmd_in) sw_r <= switch_input_pin_in; // RQ18
    end
  end
  assign qualification_mode_out = qual_r;
  assign switch_state_out = sw_r;
endmodule

// ---- bemf_stall_assertions.sv ----
// Port-level checks for the stall detector
`timescale 1ns/1ps
module bemf_stall_assertions #(
  parameter int POS_W = 16
) (
  input wire logic ref_clk_in, // In
  input wire logic rst_in, // In
  input wire logic at_max_velocity_in, // In
  input wire logic [POS_W-1:0] step_counter_in, // In
  input wire logic stall_param_write_cmd_in, // In
  input wire logic otp_param_write_cmd_in, // In
  input wire logic [3:0] absolute_threshold_in, // In
  input wire logic [3:0] delta_threshold_in, // In
  input wire logic full_status_read_cmd_in, // In
  input wire logic short_status_read_cmd_in, // In
  input wire logic bemf_observe_cmd_in, // In
  input wire logic [4:0] status_flags_out, // Out
  input wire logic halt_out, // Out
  input wire logic [POS_W-1:0] actual_position_out, // Out
  input wire logic [3:0] absolute_threshold_out, // Out
  input wire logic [3:0] delta_threshold_out, // Out
  input wire logic otp_write_out, // Out
  input wire logic [3:0] otp_abs_data_out, // Out
  input wire logic [3:0] otp_del_data_out, // Out
  input wire logic qualification_mode_out, // Out
  input wire logic switch_state_out // Out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  a_stall_or_causes: assert property (status_flags_out[3] == |status_flags_out[2:0])
    else $error("stall flag is not the OR of its causes");
  a_halt_sets_flags: assert property (halt_out |-> status_flags_out[4:3] == 2'h3)
    else $error("halt without lost-step and stall");
  a_halt_captures_pos: assert property (halt_out |-> actual_position_out == $past(step_counter_in))
    else $error("position not captured on halt");
  // A new hit while moving may set lost-step again, and then it also halts
  a_read_clears_lost: assert property (full_status_read_cmd_in || short_status_read_cmd_in |=>
    !status_flags_out[4] || halt_out) else $error("lost-step survived a status read");
  a_short_keeps_causes: assert property (short_status_read_cmd_in && !full_status_read_cmd_in |=>
    (~status_flags_out[3:0] & $past(status_flags_out[3:0])) == 4'h0) else $error("short read cleared a cause");
  a_eval_max_vel: assert property ($rose(status_flags_out[3]) |-> $past(at_max_velocity_in))
    else $error("stall raised off maximum velocity");
  a_eval_enabled: assert property ($rose(status_flags_out[3]) |->
    $past(absolute_threshold_out) != 4'h0 || $past(delta_threshold_out) != 4'h0) else $error("stall while disabled");
  // The first edge after reset loads the OTP image and overrides a write
  a_ram_write: assert property (!$past(rst_in) && stall_param_write_cmd_in |=>
    {absolute_threshold_out, delta_threshold_out} == {$past(absolute_threshold_in), $past(delta_threshold_in)})
    else $error("threshold write not taken");
  a_otp_write: assert property (otp_param_write_cmd_in |=> otp_write_out &&
    {otp_abs_data_out, otp_del_data_out} == {$past(absolute_threshold_in), $past(delta_threshold_in)})
    else $error("otp write not taken");
  a_qual_sticky: assert property (bemf_observe_cmd_in || qualification_mode_out |=> qualification_mode_out)
    else $error("qualification mode not held");
  a_switch_blocked: assert property (qualification_mode_out |=> $stable(switch_state_out))
    else $error("switch state moved in qualification mode");
  c_halt: cover property (halt_out);
  c_short_with_stall: cover property (short_status_read_cmd_in && status_flags_out[3]);
  c_qual: cover property ($rose(qualification_mode_out));
  c_abs_stall: cover property ($rose(status_flags_out[2]));
endmodule

// ---- lin_master_model.sv ----
// Master-side command source for the stall detector
`timescale 1ns/1ps
module lin_master_model (
  input wire logic ref_clk_in, // Clock
  input wire logic [4:0] status_flags_in, // Device flags
  output logic stall_param_write_cmd_out, // RAM write
  output logic otp_param_write_cmd_out, // OTP write
  output logic bemf_observe_cmd_out, // Observation
  output logic full_status_read_cmd_out, // Full read
  output logic short_status_read_cmd_out, // Short read
  output logic [3:0] absolute_threshold_out, // Absolute index
  output logic [3:0] delta_threshold_out // Delta index
);
  initial begin
    {stall_param_write_cmd_out, otp_param_write_cmd_out, bemf_observe_cmd_out} = 3'h0;
    {full_status_read_cmd_out, short_status_read_cmd_out} = 2'h0;
    {absolute_threshold_out, delta_threshold_out} = 8'h00;
  end
  // Kind 0 RAM write, 1 OTP write, 2 observation; data inverted once released
  task automatic send(input logic [1:0] kind, input logic [7:0] thr);
    @(negedge ref_clk_in);
    {absolute_threshold_out, delta_threshold_out} = thr;
    stall_param_write_cmd_out = (kind == 2'h0);
    otp_param_write_cmd_out = (kind == 2'h1);
    bemf_observe_cmd_out = (kind == 2'h2);
    @(negedge ref_clk_in);
    {stall_param_write_cmd_out, otp_param_write_cmd_out, bemf_observe_cmd_out} = 3'h0;
    {absolute_threshold_out, delta_threshold_out} = ~thr;
  endtask
  // Flags taken in the read cycle, before the clearing edge
  task automatic read(input logic full, output logic [4:0] flags);
    @(negedge ref_clk_in);
    full_status_read_cmd_out = full;
    short_status_read_cmd_out = !full;
    flags = status_flags_in;
    @(negedge ref_clk_in);
    {full_status_read_cmd_out, short_status_read_cmd_out} = 2'h0;
  endtask
endmodule

// ---- tb.sv ----
// Self-checking testbench for the back-EMF stall detector
`timescale 1ns/1ps
module tb;
  localparam int SAMPLE_CYC = 87 * 100 + 20; // Shortest delay plus margin
  logic ref_clk_in, rst_in, zero_cross_in, full_step_in, moving_in, two_phase_positioning_in, at_max_velocity_in;
  logic duty_full_in, full_duty_stall_enable_in, switch_input_pin_in, stall_param_write_cmd_in, halt_out;
  logic otp_param_write_cmd_in, full_status_read_cmd_in, short_status_read_cmd_in, bemf_observe_cmd_in;
  logic start_second_phase_out, otp_write_out, qualification_mode_out, switch_state_out;
  logic [13:0] bemf_mv_in;
  logic [2:0] sample_delay_sel_in, stall_activation_step_delay_in;
  logic [15:0] step_counter_in, actual_position_out;
  logic [3:0] otp_absolute_threshold_in, otp_delta_threshold_in, absolute_threshold_in, delta_threshold_in;
  logic [3:0] absolute_threshold_out, delta_threshold_out, otp_abs_data_out, otp_del_data_out;
  logic [4:0] status_flags_out, flags;
  int fails = 0, checks_done = 0, cycles = 0, n;
  logic [9:0] rows [6] = '{10'h000, 10'h0f0, 10'h00f, 10'h1a5, 10'h15a, 10'h014}; // {kind, abs, delta}
  bemf_stall_detector #(.STAB_CYC(10)) i_bemf_stall_detector (.ref_clk_in, .rst_in, .zero_cross_in, .bemf_mv_in,
    .sample_delay_sel_in, .stall_activation_step_delay_in, .full_duty_stall_enable_in, .duty_full_in,
    .at_max_velocity_in, .full_step_in, .moving_in, .two_phase_positioning_in, .step_counter_in,
    .otp_absolute_threshold_in, .otp_delta_threshold_in, .stall_param_write_cmd_in, .otp_param_write_cmd_in,
    .absolute_threshold_in, .delta_threshold_in, .full_status_read_cmd_in, .short_status_read_cmd_in,
    .bemf_observe_cmd_in, .switch_input_pin_in, .status_flags_out, .halt_out, .start_second_phase_out,
    .actual_position_out, .absolute_threshold_out, .delta_threshold_out, .otp_write_out, .otp_abs_data_out,
    .otp_del_data_out, .qualification_mode_out, .switch_state_out);
  lin_master_model i_lin_master_model (.ref_clk_in, .status_flags_in(status_flags_out),
    .stall_param_write_cmd_out(stall_param_write_cmd_in), .otp_param_write_cmd_out(otp_param_write_cmd_in),
    .bemf_observe_cmd_out(bemf_observe_cmd_in), .full_status_read_cmd_out(full_status_read_cmd_in),
    .short_status_read_cmd_out(short_status_read_cmd_in), .absolute_threshold_out(absolute_threshold_in),
    .delta_threshold_out(delta_threshold_in));
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk_in);
  endtask
  // One zero crossing, then wait for the halt or the shortest sample delay plus margin
  task automatic bemf_sample(input logic [13:0] mv);
    bemf_mv_in = mv;
    zero_cross_in = 1'h1;
    cyc(1);
    zero_cross_in = 1'h0;
    n = 0;
    while (halt_out !== 1'h1 && n < SAMPLE_CYC) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'h0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // Ten real sample delays dominate the run
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 95000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    {zero_cross_in, full_step_in, moving_in, two_phase_positioning_in, at_max_velocity_in} = 5'h00;
    {duty_full_in, full_duty_stall_enable_in, switch_input_pin_in} = 3'h7;
    {sample_delay_sel_in, stall_activation_step_delay_in} = 6'h02;
    {otp_absolute_threshold_in, otp_delta_threshold_in} = 8'h36;
    bemf_mv_in = 14'h0000;
    step_counter_in = 16'h1234;
    rst_in = 1'h1;
    cyc(10);
    rst_in = 1'h0;
    cyc(2);
    chk({absolute_threshold_out, delta_threshold_out}, 16'h0036);
    foreach (rows[i]) begin
      i_lin_master_model.send(rows[i][9:8], rows[i][7:0]);
      if (rows[i][8]) chk({otp_write_out, otp_abs_data_out, otp_del_data_out}, {1'h1, rows[i][7:0]});
      else chk({absolute_threshold_out, delta_threshold_out}, rows[i][7:0]);
    end
    {moving_in, two_phase_positioning_in, at_max_velocity_in} = 3'h7;
    repeat (2) begin
      full_step_in = 1'h1;
      cyc(1);
      full_step_in = 1'h0;
      cyc(1);
    end
    // Eight steady samples fill the window, the ninth jumps by 2 V
    for (int s = 0; s < 9; s++) begin
      step_counter_in = (s < 8) ? 16'h1234 : 16'h2345;
      bemf_sample((s < 8) ? 14'h0bb8 : 14'h1388);
      if (s == 7) chk(status_flags_out, 5'h00);
    end
    chk({halt_out, status_flags_out}, 6'h39);
    chk(actual_position_out, 16'h2345);
    n = 0;
    while (start_second_phase_out !== 1'h1 && n < 20) begin
      cyc(1);
      n++;
    end
    chk(16'(n), 16'h000a);
    step_counter_in = 16'h3456;
    cyc(2);
    chk(actual_position_out, 16'h2345);
    i_lin_master_model.read(1'h0, flags);
    chk({flags, 3'h0, status_flags_out}, 13'h1909);
    i_lin_master_model.read(1'h1, flags);
    chk({flags, 3'h0, status_flags_out}, 13'h0900);
    cyc(2);
    chk({actual_position_out, switch_state_out}, 17'h068ad);
    // Average is 3250 mV; a 7.5 V absolute level and a 0 V sample trip abs and delta-low
    i_lin_master_model.send(2'h0, 8'hf4);
    bemf_sample(14'h0000);
    chk({halt_out, status_flags_out}, 6'h3e);
    chk(actual_position_out, 16'h3456);
    i_lin_master_model.send(2'h2, 8'h00);
    chk(qualification_mode_out, 1'h1);
    switch_input_pin_in = 1'h0;
    cyc(3);
    chk(switch_state_out, 1'h1);
    {otp_absolute_threshold_in, otp_delta_threshold_in} = 8'h5a;
    rst_in = 1'h1;
    cyc(2);
    rst_in = 1'h0;
    cyc(2);
    chk({qualification_mode_out, absolute_threshold_out, delta_threshold_out}, 9'h05a);
    conclude();
  end
endmodule
bind bemf_stall_detector bemf_stall_assertions #(.POS_W(POS_W)) i_bemf_stall_assertions (.ref_clk_in, .rst_in,
  .at_max_velocity_in, .step_counter_in, .stall_param_write_cmd_in, .otp_param_write_cmd_in,
  .absolute_threshold_in, .delta_threshold_in, .full_status_read_cmd_in, .short_status_read_cmd_in,
  .bemf_observe_cmd_in, .status_flags_out, .halt_out, .actual_position_out, .absolute_threshold_out,
  .delta_threshold_out, .otp_write_out, .otp_abs_data_out, .otp_del_data_out, .qualification_mode_out,
  .switch_state_out);
